// ---- snf_defs.svh ----
// opcode, timing and layout constants of the serial flash core
// assumes a 20 MHz ref_clk; all times below are in nanoseconds
`ifndef SNF_DEFS_SVH
`define SNF_DEFS_SVH

// instruction codes
`define SNF_OP_FAST 8'h0B
`define SNF_OP_DUAL 8'h3B
`define SNF_OP_MDID 8'h90
`define SNF_OP_JID 8'h9F
`define SNF_OP_UID 8'h4B
`define SNF_OP_SLEEP 8'hB9
`define SNF_OP_WAKE 8'hAB
`define SNF_OP_PROG 8'h02
`define SNF_OP_WREN 8'h06
`define SNF_OP_WRDI 8'h04
`define SNF_OP_RDSR 8'h05

// clock edge count after which output data starts
`define SNF_START_OP 16'h0008
`define SNF_START_ADDR 16'h0020
`define SNF_START_LONG 16'h0028
`define SNF_START_NONE 16'hFFFF
// first edge count that completes a program data byte
`define SNF_PROG_DATA 16'h0028

// times and derived ref_clk cycle counts (longest times round down)
`define SNF_REF_CLK_NS 50
`define SNF_SLEEP_ENTRY_NS 3000
`define SNF_WAKE_PLAIN_NS 3000
`define SNF_WAKE_ID_NS 3000
`define SNF_PAGE_PROG_NS 700000
`define SNF_SLEEP_ENTRY_CYC (`SNF_SLEEP_ENTRY_NS / `SNF_REF_CLK_NS)
`define SNF_WAKE_PLAIN_CYC (`SNF_WAKE_PLAIN_NS / `SNF_REF_CLK_NS)
`define SNF_WAKE_ID_CYC (`SNF_WAKE_ID_NS / `SNF_REF_CLK_NS)
`define SNF_PAGE_PROG_CYC (`SNF_PAGE_PROG_NS / `SNF_REF_CLK_NS)

`endif

// ---- snf_pkg.sv ----
// types shared by the serial flash core
// assumes nothing of its surroundings
package snf_pkg;
    // one-hot states of the self-timed controller
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_PROG = 5'h02,
        ST_DOZE = 5'h04,
        ST_ASLEEP = 5'h08,
        ST_WAKE = 5'h10
    } snf_state_t;
endpackage : snf_pkg

// ---- snf_mem.sv ----
// simple two-clock byte memory, registered read data
// assumes write and read of one address never race across clocks
`timescale 1ns/10ps
`default_nettype none
module snf_mem #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    input wire logic wr_clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic rd_clk,
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);
    // storage array, no reset: contents are data, not control
    logic [DW-1:0] mem [2**AW];

    // write port
    always_ff @(posedge wr_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // read port, one cycle latency
    always_ff @(posedge rd_clk) begin
        rd_data <= mem[rd_addr];
    end
endmodule : snf_mem
`default_nettype wire

// ---- snf_core.sv ----
// serial nor flash instruction core: reads, ids, sleep, page program
// assumes an spi host in mode 0/3; sclk stands still while cs_n is high
// Behaviour
// R1: fast read takes address, dummy, rising-edge sampling
// R2: fast read shifts falling edge, address increments
// R3: dual read sends two bits per clock
// R4: id read address bit zero picks first code
// R5: standard id gives maker, type, capacity bytes
// R6: standard id ignored while programming
// R7: raising select ends id read, back idle
// R8: unique id after four dummy bytes, 64 bits
// R9: sleep only if select rises after bit eight
// R10: asleep, only release opcode is recognised
// R11: power-up leaves device awake and idle
// R12: plain release wakes after first wake time
// R13: release with dummies repeats device code
// R14: release with id uses second wake time
// R15: release opcode ignored while write in progress
// R16: program needs write enable latch set
// R17: program data wraps within the page
// R18: only last 256 program bytes kept
// R19: unsent page bytes stay unchanged
// R20: program needs select rise on byte boundary
// R21: select rise starts timed program, busy flag
// R22: protected pages are never programmed
// R23: dual lines carry odd and even bits
// R24: write-type opcodes need whole-byte frames
// R25: bits captured msb first from first clock
`timescale 1ns/10ps
`default_nettype none
`include "snf_defs.svh"
module snf_core import snf_pkg::*; #(
    parameter int ADDR_W = 17,
    parameter int PP_CYCLES = `SNF_PAGE_PROG_CYC,
    parameter logic [7:0] MFR_CODE = 8'h5A, // arbitrary value
    parameter logic [7:0] TYPE_CODE = 8'h41, // arbitrary value
    parameter logic [7:0] CAP_CODE = 8'h3C, // arbitrary value
    parameter logic [7:0] DEV_CODE = 8'h2D, // arbitrary value
    parameter logic [63:0] UID_CODE = 64'h0123456789ABCDEF // arbitrary
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic si_in,
    output logic io0_out,
    output logic io0_oe,
    output logic so_out,
    output logic so_oe,
    input wire logic [2:0] block_protect_bits,
    output logic write_in_progress,
    output logic write_enable_latch,
    output logic deep_sleep_state
);
    localparam int PW = ADDR_W - 8; // page number width
    localparam int SLEEP_A = `SNF_SLEEP_ENTRY_CYC + 2;
    localparam int WAKE_A = `SNF_WAKE_ID_CYC + `SNF_WAKE_PLAIN_CYC + 2;

    // refuse sizes the counters and address fields cannot hold
    if (ADDR_W < 9 || ADDR_W > 24 || PP_CYCLES < 300 ||
        PP_CYCLES > 65535) begin : g_bad_param
        $error("snf_core: unsupported ADDR_W or PP_CYCLES");
    end

    ////////////////////////////////////////////////////////////////////
    // decoding helpers
    ////////////////////////////////////////////////////////////////////
    // edge count after which an opcode starts sending data
    function automatic logic [15:0] data_start(input logic [7:0] code);
        case (code)
            `SNF_OP_FAST, `SNF_OP_DUAL, `SNF_OP_UID: begin
                data_start = `SNF_START_LONG; // see R1 see R8
            end
            `SNF_OP_MDID, `SNF_OP_WAKE: data_start = `SNF_START_ADDR;
            `SNF_OP_JID, `SNF_OP_RDSR: data_start = `SNF_START_OP;
            default: data_start = `SNF_START_NONE;
        endcase
    endfunction : data_start

    // which opcodes are decoded in the current device condition
    function automatic logic cmd_allowed(input logic [7:0] code,
                                         input logic busy,
                                         input logic asleep);
        if (asleep) begin
            cmd_allowed = (code == `SNF_OP_WAKE); // see R10
        end else if (busy) begin
            // status reads only; id reads dropped, cycle untouched
            cmd_allowed = (code == `SNF_OP_RDSR); // see R6 see R15
        end else begin
            cmd_allowed = 1'b1;
        end
    endfunction : cmd_allowed

    // page lies in the protected top fraction chosen by the bits
    function automatic logic page_prot(input logic [PW-1:0] pg,
                                       input logic [2:0] bp);
        logic [PW:0] first;
        first = (PW+1)'(2**PW) - ((PW+1)'(2**PW) >> (3'h7 - bp));
        page_prot = (bp != 3'h0) && ({1'b0, pg} >= first);
    endfunction : page_prot

    ////////////////////////////////////////////////////////////////////
    // link side, clocked by sclk
    ////////////////////////////////////////////////////////////////////
    logic started; // first rising edge of frame seen
    logic [15:0] bit_cnt; // rising edges this frame, kept after cs
    logic [15:0] next_cnt;
    logic [7:0] rx_sh; // serial input shifter
    logic [7:0] rx_byte;
    logic [7:0] op; // opcode of current/last frame
    logic [23:0] addr; // address bytes as received
    logic cmd_ok; // opcode accepted at bit eight
    logic [ADDR_W-1:0] rd_ptr; // read address into the array
    logic [7:0] out_cnt; // data bytes already loaded
    logic [7:0] wr_idx; // byte slot inside the page
    logic [255:0] wmask; // page slots written this frame
    logic [PW-1:0] lk_page; // page aimed at by program
    logic [5:0] lk_s1, lk_s2; // sleep, wip, wel, protect bits
    logic quiet; // ref side: asleep or on the way in/out
    logic [7:0] mem_q, cur_byte, tx;
    logic [63:0] uid_word;
    logic [15:0] dstart, rel;
    logic dual, out_on, load_now, buf_we;

    // frame start marker, cleared while deselected
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            started <= 1'b0;
        end else begin
            started <= 1'b1;
        end
    end

    // status levels into the link domain, two flops each
    always_ff @(posedge sclk) begin
        lk_s1 <= {quiet, write_in_progress, write_enable_latch,
                  block_protect_bits};
        lk_s2 <= lk_s1;
    end

    assign next_cnt = started ? bit_cnt + 16'h0001 : 16'h0001;
    assign rx_byte = {rx_sh[6:0], si_in}; // see R25

    // bit counter and input shifter on every rising edge
    always_ff @(posedge sclk) begin
        bit_cnt <= next_cnt;
        rx_sh <= rx_byte; // see R1
    end

    // opcode and address capture, msb first from first clock
    always_ff @(posedge sclk) begin
        if (next_cnt == 16'h0008) begin // see R25
            op <= rx_byte;
            cmd_ok <= cmd_allowed(rx_byte, lk_s2[4], lk_s2[5]);
        end
        if (next_cnt == 16'h0010) begin
            addr[23:16] <= rx_byte;
        end
        if (next_cnt == 16'h0018) begin
            addr[15:8] <= rx_byte;
        end
        if (next_cnt == 16'h0020) begin
            addr[7:0] <= rx_byte;
        end
    end

    assign dstart = data_start(op);
    assign rel = bit_cnt - dstart;
    assign dual = (op == `SNF_OP_DUAL);
    assign out_on = started && cmd_ok && (bit_cnt >= dstart);
    // a byte is loaded every 8 clocks, or every 4 when dual
    assign load_now = out_on &&
        (dual ? (rel[1:0] == 2'h0) : (rel[2:0] == 3'h0)); // see R3

    // read pointer and byte count advance after each loaded byte
    always_ff @(posedge sclk) begin
        if (next_cnt == 16'h0020) begin
            rd_ptr <= {addr[ADDR_W-1:8], rx_byte}; // see R2
        end else if (load_now) begin
            rd_ptr <= rd_ptr + 1'b1; // see R2 see R3
        end
        // count restarts with the opcode, before any id byte goes out
        if (next_cnt == 16'h0008) begin
            out_cnt <= 8'h00; // see R5
        end else if (load_now) begin
            out_cnt <= out_cnt + 8'h01;
        end
    end

    // byte to send next; id bytes depend on bytes already sent
    always_comb begin
        uid_word = UID_CODE << {out_cnt[2:0], 3'h0};
        case (op)
            `SNF_OP_FAST, `SNF_OP_DUAL: cur_byte = mem_q;
            `SNF_OP_JID: begin
                case (out_cnt) // see R5
                    8'h00: cur_byte = MFR_CODE;
                    8'h01: cur_byte = TYPE_CODE;
                    8'h02: cur_byte = CAP_CODE;
                    default: cur_byte = 8'h00;
                endcase
            end
            `SNF_OP_MDID: begin
                // codes alternate; address bit zero picks the first
                cur_byte = (out_cnt[0] ^ addr[0]) ? DEV_CODE
                                                  : MFR_CODE; // see R4
            end
            `SNF_OP_WAKE: cur_byte = DEV_CODE; // see R13
            `SNF_OP_UID: cur_byte = uid_word[63:56]; // see R8
            `SNF_OP_RDSR: cur_byte = {3'h0, lk_s2[2:0], lk_s2[3],
                                      lk_s2[4]};
            default: cur_byte = 8'hFF;
        endcase
    end

    // output shifter on falling edges; drivers drop with cs high
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin // see R7
            so_out <= 1'b0;
            so_oe <= 1'b0;
            io0_out <= 1'b0;
            io0_oe <= 1'b0;
            tx <= 8'h00;
        end else if (out_on && dual) begin
            // io1 gets bits 7,5,3,1 and io0 bits 6,4,2,0
            so_oe <= 1'b1;
            io0_oe <= 1'b1;
            if (load_now) begin
                so_out <= cur_byte[7]; // see R23
                io0_out <= cur_byte[6];
                tx <= {cur_byte[5:0], 2'h0};
            end else begin
                so_out <= tx[7]; // see R23
                io0_out <= tx[6];
                tx <= {tx[5:0], 2'h0};
            end
        end else if (out_on) begin
            so_oe <= 1'b1;
            if (load_now) begin
                so_out <= cur_byte[7]; // see R2 see R5
                tx <= {cur_byte[6:0], 1'b0};
            end else begin
                so_out <= tx[7];
                tx <= {tx[6:0], 1'b0};
            end
        end
    end

    // program data lands in the page buffer, index wraps at 256
    assign buf_we = (op == `SNF_OP_PROG) && cmd_ok && started &&
        (next_cnt >= `SNF_PROG_DATA) && (next_cnt[2:0] == 3'h0);

    // later bytes overwrite earlier ones in the same slot
    always_ff @(posedge sclk) begin
        if (next_cnt == 16'h0020 && op == `SNF_OP_PROG && cmd_ok) begin
            wr_idx <= rx_byte;
            wmask <= '0; // see R19
            lk_page <= addr[ADDR_W-1:8];
        end else if (buf_we) begin
            wmask[wr_idx] <= 1'b1; // see R19
            wr_idx <= wr_idx + 8'h01; // see R17 see R18
        end
    end

    ////////////////////////////////////////////////////////////////////
    // controller side, clocked by ref_clk
    ////////////////////////////////////////////////////////////////////
    snf_state_t st;
    logic cs_s1, cs_s2, cs_s3;
    logic [2:0] bp_s1, bp_s2;
    logic [15:0] timer;
    logic frame_end, aligned, prog_go, dp_go, rel_go;
    logic wren_go, wrdi_go;
    logic walk_on, wq_valid, walk_last, flash_we;
    logic [7:0] walk_idx, wq_idx, buf_q;
    logic [PW-1:0] prog_page;

    // select and protect pins, two flops before any use
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_s3 <= 1'b1;
            bp_s1 <= 3'h0;
            bp_s2 <= 3'h0;
        end else begin
            cs_s1 <= cs_n;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
            bp_s1 <= block_protect_bits;
            bp_s2 <= bp_s1;
        end
    end

    // frame data is static once cs is high and sclk has stopped
    assign frame_end = cs_s2 && !cs_s3;
    assign aligned = (bit_cnt[2:0] == 3'h0); // see R24
    assign prog_go = frame_end && op == `SNF_OP_PROG && cmd_ok &&
        aligned && bit_cnt >= `SNF_PROG_DATA && // see R20
        write_enable_latch && st == ST_IDLE && // see R16
        !page_prot(lk_page, bp_s2); // see R22
    assign dp_go = frame_end && op == `SNF_OP_SLEEP &&
        bit_cnt == 16'h0008 && st == ST_IDLE; // see R9
    assign rel_go = frame_end && op == `SNF_OP_WAKE &&
        bit_cnt >= 16'h0008 && st == ST_ASLEEP; // see R12
    assign wren_go = frame_end && op == `SNF_OP_WREN && aligned &&
        bit_cnt != 16'h0000 && st == ST_IDLE; // see R24
    assign wrdi_go = frame_end && op == `SNF_OP_WRDI && aligned &&
        bit_cnt != 16'h0000 && st == ST_IDLE; // see R24

    // self-timed cycles: program, sleep entry, wake-up
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin // see R11
            st <= ST_IDLE;
            timer <= 16'h0000;
            write_in_progress <= 1'b0;
            deep_sleep_state <= 1'b0;
            quiet <= 1'b0;
        end else begin
            case (st)
                ST_IDLE: begin
                    if (prog_go) begin
                        st <= ST_PROG;
                        timer <= 16'(PP_CYCLES - 1);
                        write_in_progress <= 1'b1; // see R21
                    end else if (dp_go) begin
                        st <= ST_DOZE;
                        timer <= 16'(`SNF_SLEEP_ENTRY_CYC - 1);
                        quiet <= 1'b1;
                    end
                end
                ST_PROG: begin
                    if (timer == 16'h0000) begin
                        st <= ST_IDLE;
                        write_in_progress <= 1'b0; // see R21
                    end else begin
                        timer <= timer - 16'h0001;
                    end
                end
                ST_DOZE: begin
                    if (timer == 16'h0000) begin
                        st <= ST_ASLEEP;
                        deep_sleep_state <= 1'b1; // see R9
                    end else begin
                        timer <= timer - 16'h0001;
                    end
                end
                ST_ASLEEP: begin
                    if (rel_go) begin
                        st <= ST_WAKE;
                        // id read in the frame picks the id wake time, equal to the plain one
                        timer <= (bit_cnt == 16'h0008)
                            ? 16'(`SNF_WAKE_PLAIN_CYC - 1) // see R12
                            : 16'(`SNF_WAKE_ID_CYC - 1); // see R14
                    end
                end
                ST_WAKE: begin
                    if (timer == 16'h0000) begin
                        st <= ST_IDLE;
                        deep_sleep_state <= 1'b0;
                        quiet <= 1'b0;
                    end else begin
                        timer <= timer - 16'h0001;
                    end
                end
                default: st <= ST_IDLE;
            endcase
        end
    end

    // walk all 256 slots, writing only those sent this frame
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            walk_on <= 1'b0;
            walk_idx <= 8'h00;
            wq_valid <= 1'b0;
            wq_idx <= 8'h00;
            prog_page <= '0;
        end else begin
            if (prog_go) begin
                walk_on <= 1'b1;
                walk_idx <= 8'h00;
                prog_page <= lk_page; // see R17
            end else if (walk_on) begin
                walk_idx <= walk_idx + 8'h01;
                walk_on <= (walk_idx != 8'hFF);
            end
            wq_valid <= walk_on;
            wq_idx <= walk_idx;
        end
    end

    assign walk_last = wq_valid && wq_idx == 8'hFF;
    assign flash_we = wq_valid && wmask[wq_idx]; // see R19

    // latch is cleared when the walk ends, ahead of busy dropping
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            write_enable_latch <= 1'b0;
        end else if (wren_go) begin
            write_enable_latch <= 1'b1;
        end else if (wrdi_go || walk_last) begin
            write_enable_latch <= 1'b0; // see R21
        end
    end

    // page buffer: filled from the link, drained by the walk
    snf_mem #(.AW(8), .DW(8)) u_page (
        .wr_clk(sclk),
        .wr_en(buf_we),
        .wr_addr(wr_idx),
        .wr_data(rx_byte),
        .rd_clk(ref_clk),
        .rd_addr(walk_idx),
        .rd_data(buf_q)
    );

    // main array: written by the walk, read by the link
    snf_mem #(.AW(ADDR_W), .DW(8)) u_array (
        .wr_clk(ref_clk),
        .wr_en(flash_we),
        .wr_addr({prog_page, wq_idx}),
        .wr_data(buf_q),
        .rd_clk(sclk),
        .rd_addr(rd_ptr),
        .rd_data(mem_q)
    );

    ////////////////////////////////////////////////////////////////////
    // checks
    ////////////////////////////////////////////////////////////////////
    prog_busy_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        prog_go |=> write_in_progress [*8]) // see R21
        else $error("busy flag not held after program start");
    wel_early_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $fell(write_in_progress) |-> !write_enable_latch) // see R21
        else $error("latch still set when program ended");
    prog_wel_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(write_in_progress) |-> $past(write_enable_latch)) // see R16
        else $error("program started without write enable");
    prot_skip_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        frame_end && op == `SNF_OP_PROG && page_prot(lk_page, bp_s2)
        |=> !$rose(write_in_progress)) // see R22
        else $error("protected page was programmed");
    sleep_in_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        dp_go |-> ##[1:SLEEP_A] deep_sleep_state) // see R9
        else $error("sleep not entered in time");
    sleep_odd_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        st == ST_IDLE && frame_end && op == `SNF_OP_SLEEP &&
        bit_cnt != 16'h0008 |=> st == ST_IDLE) // see R24
        else $error("sleep taken on a bad frame length");
    wake_out_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        rel_go |-> ##[1:WAKE_A] !deep_sleep_state) // see R12
        else $error("wake-up took too long");
    asleep_mute_a: assert property (@(negedge sclk) disable iff (cs_n)
        so_oe && lk_s2[5] |-> op == `SNF_OP_WAKE) // see R10
        else $error("output while asleep on other opcode");
    busy_jid_a: assert property (@(posedge sclk) disable iff (cs_n)
        bit_cnt == 16'h0008 && op == `SNF_OP_JID && $past(lk_s2[4])
        |-> !cmd_ok) // see R6
        else $error("id read decoded while busy");
    page_wrap_a: assert property (@(posedge sclk) disable iff (cs_n)
        buf_we && wr_idx == 8'hFF |=> wr_idx == 8'h00) // see R17
        else $error("program index left the page");

    prog_done_c: cover property (@(posedge ref_clk) $fell(write_in_progress));
    asleep_c: cover property (@(posedge ref_clk) $rose(deep_sleep_state));
    dual_c: cover property (@(negedge sclk) io0_oe && so_oe);
    fast_c: cover property (@(negedge sclk) so_oe && op == `SNF_OP_FAST);
endmodule : snf_core
`default_nettype wire

// ---- snf_host.sv ----
// spi host model: select, serial clock and serial in
// assumes mode 0; clock stands still outside frames
`timescale 1ns/10ps
`default_nettype none
module snf_host (
    output logic sclk,
    output logic cs_n,
    output logic si_in,
    input wire logic so_out,
    input wire logic io0_out
);
    // idle: deselected, clock low
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si_in = 1'b0;
    end
    // open a frame, phase unrelated to ref_clk
    task automatic start;
        #11 cs_n = 1'b0;
    endtask : start
    // one byte msb first, 48 ns per clock; dual packs two bits per clock
    task automatic xfer(input logic [7:0] tx, input bit dual,
                        output logic [7:0] rx);
        for (int i = 0; i < (dual ? 4 : 8); i++) begin
            si_in = tx[7-i];
            #24 sclk = 1'b1;
            rx = dual ? {rx[5:0], so_out, io0_out} : {rx[6:0], so_out};
            #24 sclk = 1'b0;
        end
    endtask : xfer
    // close on a byte boundary, then honour the gap between frames
    task automatic stop;
        #20 cs_n = 1'b1;
        si_in = ~si_in; // released line must not keep its value
        #400;
    endtask : stop
endmodule : snf_host
`default_nettype wire

// ---- snf_core_tb.sv ----
// self-checking bench of the serial flash core
// assumes snf_core, snf_mem and snf_host are compiled before it
`timescale 1ns/10ps
`default_nettype none
module snf_core_tb;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [2:0] bp = 3'h0; // protection off until the last test sets all bits
    logic sclk, cs_n, host_si, io0_out, io0_oe, so_out, so_oe;
    logic write_in_progress, write_enable_latch, deep_sleep_state;
    int n_errors = 0;
    int n_checks = 0;
    // io0 wire: device wins while it drives in dual mode
    wire logic si_wire = io0_oe ? io0_out : host_si;
    always #25 ref_clk = ~ref_clk;
    snf_core #(.PP_CYCLES(300)) DUT (.ref_clk(ref_clk), .reset_n(reset_n),
        .sclk(sclk), .cs_n(cs_n), .si_in(si_wire), .io0_out(io0_out),
        .io0_oe(io0_oe), .so_out(so_out), .so_oe(so_oe),
        .block_protect_bits(bp), .write_in_progress(write_in_progress),
        .write_enable_latch(write_enable_latch),
        .deep_sleep_state(deep_sleep_state));
    snf_host HOST (.sclk(sclk), .cs_n(cs_n), .si_in(host_si),
        .so_out(so_out), .io0_out(io0_out));
    ////////////////////////////////////////////////////////////////////////
    // verdict, reached from the main sequence or the watchdog
    task automatic tally_and_finish;
        if (n_errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish
    // compare one byte-wide result
    task automatic chk(input string nm, input logic [7:0] exp,
                       input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // open a frame and send the given bytes
    task automatic send(input logic [7:0] q[$]);
        logic [7:0] r;
        HOST.start();
        foreach (q[i]) HOST.xfer(q[i], 1'b0, r);
    endtask : send
    // clock one data byte out of the device and compare it
    task automatic rd(input string nm, input logic [7:0] exp, input bit dual);
        logic [7:0] r;
        HOST.xfer(8'h00, dual, r);
        chk(nm, exp, r);
    endtask : rd
    // bounded wait for the busy or sleep flag to reach a level
    task automatic wait_flag(input bit slp, input logic v);
        int k;
        for (k = 0; k < 400; k++) begin
            @(posedge ref_clk);
            if ((slp ? deep_sleep_state : write_in_progress) === v) break;
        end
        chk(slp ? "sleep" : "wip", {7'h00, v},
            {7'h00, slp ? deep_sleep_state : write_in_progress});
    endtask : wait_flag
    ////////////////////////////////////////////////////////////////////////
    // watchdog: whole run is well under 100 us
    initial begin
        #400000;
        n_errors++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        repeat (8) @(posedge ref_clk);
        #5 reset_n = 1'b1;
        repeat (6) @(posedge ref_clk);
        chk("wip", 8'h00, {7'h00, write_in_progress});
        chk("sleep", 8'h00, {7'h00, deep_sleep_state});
        send('{8'h9F});
        rd("mfr", 8'h5A, 1'b0);
        rd("type", 8'h41, 1'b0);
        HOST.stop();
        send('{8'h90, 8'h00, 8'h00, 8'h01});
        rd("dev", 8'h2D, 1'b0);
        rd("mfr2", 8'h5A, 1'b0);
        HOST.stop();
        send('{8'h4B, 8'h00, 8'h00, 8'h00, 8'h00});
        rd("uid", 8'h01, 1'b0);
        HOST.stop();
        send('{8'h06});
        HOST.stop();
        chk("wel", 8'h01, {7'h00, write_enable_latch});
        send('{8'h05});
        rd("status", 8'h02, 1'b0);
        HOST.stop();
        // program across the page end: last byte wraps to offset 0
        send('{8'h02, 8'h00, 8'h00, 8'hFE, 8'hA1, 8'hB2, 8'hC3});
        HOST.stop();
        chk("wip_on", 8'h01, {7'h00, write_in_progress});
        send('{8'h9F});
        rd("busy_jid", 8'h00, 1'b0);
        HOST.stop();
        send('{8'hAB, 8'h00, 8'h00, 8'h00});
        #10 chk("busy_ab", 8'h00, {7'h00, so_oe});
        HOST.stop();
        wait_flag(1'b0, 1'b0);
        chk("wel_off", 8'h00, {7'h00, write_enable_latch});
        send('{8'h0B, 8'h00, 8'h00, 8'hFE, 8'h00});
        rd("fr0", 8'hA1, 1'b0);
        rd("fr1", 8'hB2, 1'b0);
        HOST.stop();
        send('{8'h3B, 8'h00, 8'h00, 8'h00, 8'h00});
        rd("dual", 8'hC3, 1'b1);
        HOST.stop();
        send('{8'hB9});
        HOST.stop();
        wait_flag(1'b1, 1'b1);
        send('{8'h05, 8'h00});
        chk("asleep", 8'h00, {7'h00, so_oe});
        HOST.stop();
        send('{8'hAB});
        HOST.stop();
        wait_flag(1'b1, 1'b0);
        send('{8'hAB, 8'h00, 8'h00, 8'h00});
        rd("ab_id", 8'h2D, 1'b0);
        HOST.stop();
        // every page protected: program must be dropped, latch kept
        @(posedge ref_clk);
        #5 bp = 3'h7;
        send('{8'h06});
        HOST.stop();
        send('{8'h02, 8'h00, 8'h01, 8'h00, 8'h55});
        HOST.stop();
        chk("prot", 8'h00, {7'h00, write_in_progress});
        chk("wel_kept", 8'h01, {7'h00, write_enable_latch});
        send('{8'h04});
        HOST.stop();
        chk("wel_clr", 8'h00, {7'h00, write_enable_latch});
        tally_and_finish();
    end
endmodule : snf_core_tb
`default_nettype wire
